// file: pfm_pkg.sv
// pin function multiplexer constants: select codes, reset defaults, timing
// assumes a single 100 MHz clock domain and no register bus
// How it works
// RULE_01: after any reset every pin carries its first listed function until software picks another.
// RULE_02: software picks a pin's alternative through a port peripheral-enable bit and a system-unit select field.
// RULE_03: in port mode each pin has its own direction bit, input or output.
// RULE_04: while the reset pin is low and still a reset pin, the whole device is held in reset.
// RULE_05: internal reset is released synchronously after a fixed count of clock cycles.
// RULE_06: with the reset pin in port mode, only power-on, watchdog or software reset can reset the device.
// RULE_07: the test clock pin clocks the test logic and shifts data through the debug port.
// RULE_08: after reset the test clock pin is the test clock, not a port bit.
// RULE_09: after reset the reset pin is the reset input, not a port bit.
// RULE_10: after reset both oscillator pins are port bits with crystal and clock inputs disconnected.
// RULE_11: the transmit alternative drives transmit data, or the shared line in single-wire operation.
// RULE_12: the buffered clock output takes its source from the clock-out source field.
// RULE_13: after reset the transmit/crossbar/clock-out pin is a port bit.
// RULE_14: after reset the receive/crossbar/comparator/pwm pin is a port bit.
// RULE_15: one pin position offers crossbar output eleven on one member and timer b channel 0 on the others.
// RULE_16: each pin carries exactly one function and every unselected peripheral signal is isolated from it.
package pfm_pkg;
   localparam int unsigned PFM_NPINS = 7;
   // pin indices
   localparam int unsigned PIN_TCK = 0;
   localparam int unsigned PIN_RST = 1;
   localparam int unsigned PIN_C0 = 2;
   localparam int unsigned PIN_C1 = 3;
   localparam int unsigned PIN_C2 = 4;
   localparam int unsigned PIN_F8 = 5;
   localparam int unsigned PIN_C3 = 6;
   // alternative select codes
   localparam logic [1:0] SEL_ALT0 = 2'h0;
   localparam logic [1:0] SEL_ALT1 = 2'h1;
   localparam logic [1:0] SEL_ALT2 = 2'h2;
   localparam logic [1:0] SEL_ALT3 = 2'h3;
   // clock-out source codes
   localparam logic [1:0] CLKO_SRC_SYS = 2'h0;
   localparam logic [1:0] CLKO_SRC_BUS = 2'h1;
   localparam logic [1:0] CLKO_SRC_OSC = 2'h2;
   localparam logic [1:0] CLKO_SRC_OFF = 2'h3;
   // member variant: crossbar variant vs timer variant
   localparam logic MEMBER_XBAR = 1'b1;
   // reset release: cycles held after reset sources drop
   localparam int unsigned RST_HOLD_CYC = 32;
   localparam int unsigned RST_CNT_W = 6;
endpackage : pfm_pkg

// file: pfm_rst_sync.sv
// reset release sequencer: async assert, synchronous release after a count
// assumes the request input is already a level in the clock domain
`timescale 1ns/1ps
`default_nettype none
module pfm_rst_sync
   import pfm_pkg::*;
#(
   parameter int unsigned HOLD = RST_HOLD_CYC,
   parameter int unsigned W = RST_CNT_W
) (
   // clock and async reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // request and released reset
   input wire logic i_req,
   output logic o_rst_n
);
   logic [W-1:0] cnt_q, cnt_d;
   logic rst_n_q, rst_n_d;

   always_comb begin
      cnt_d = cnt_q;
      rst_n_d = rst_n_q;
      if (i_req) begin
         cnt_d = '0;
         rst_n_d = 1'b0;
      end else if (cnt_q != W'(HOLD)) begin
         cnt_d = cnt_q + W'(1);
      end else begin
         rst_n_d = 1'b1; // [RULE_05]
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
         rst_n_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         rst_n_q <= rst_n_d;
      end
   end

   assign o_rst_n = rst_n_q;
endmodule // pfm_rst_sync
`default_nettype wire

// file: pfm_pin_mux.sv
// pin function multiplexer for the first seven package pins
// assumes pad buffers outside; pads are split into in/out/output-enable signals
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux
   import pfm_pkg::*;
#(
   parameter logic MEMBER = MEMBER_XBAR,
   parameter int unsigned HOLD = RST_HOLD_CYC
) (
   // clock and power-on reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // other reset sources
   input wire logic i_watchdog_reset_source,
   input wire logic i_sw_reset,
   // configuration from port and system-integration unit
   input wire logic [PFM_NPINS-1:0] i_periph_en,
   input wire logic [2*PFM_NPINS-1:0] i_periph_sel,
   input wire logic [PFM_NPINS-1:0] i_port_dir,
   input wire logic [PFM_NPINS-1:0] i_port_dout,
   input wire logic [1:0] i_clock_out_source_field,
   // pads
   input wire logic [PFM_NPINS-1:0] i_pad_in,
   output logic [PFM_NPINS-1:0] o_pad_out,
   output logic [PFM_NPINS-1:0] o_pad_oe,
   // port input readback
   output logic [PFM_NPINS-1:0] o_port_din,
   // debug port
   output logic o_test_clk,
   // oscillator
   output logic o_crystal_input,
   output logic o_crystal_en,
   input wire logic i_crystal_output,
   output logic o_ext_clock_input_a,
   output logic o_ext_clock_input_b,
   // serial port a
   input wire logic i_serial_a_transmit,
   input wire logic i_serial_a_tx_oe,
   output logic o_serial_a_receive,
   // crossbar / timers / comparators / pwm
   input wire logic i_crossbar_out_eleven,
   input wire logic i_crossbar_out_ten,
   output logic o_crossbar_in_two,
   input wire logic i_timer_b_chan0,
   input wire logic i_timer_b_chan0_oe,
   output logic o_timer_b_chan0,
   input wire logic i_timer_b_chan1,
   input wire logic i_timer_b_chan1_oe,
   output logic o_timer_b_chan1,
   input wire logic i_timer_a_chan0,
   input wire logic i_timer_a_chan0_oe,
   output logic o_timer_a_chan0,
   input wire logic i_comparator_a_out,
   input wire logic i_comparator_d_out,
   input wire logic i_pwm_sub2_x_pin,
   input wire logic i_pwm_sub2_x_oe,
   output logic o_pwm_sub2_x_pin,
   // clock sources for buffered output
   input wire logic i_sys_clk_src,
   input wire logic i_bus_clk_src,
   input wire logic i_osc_clk_src,
   // internal device reset
   output logic o_chip_reset_n
);
   // config registers taken from the software-facing inputs
   logic [PFM_NPINS-1:0] en_q, en_d;
   logic [2*PFM_NPINS-1:0] sel_q, sel_d;
   logic [PFM_NPINS-1:0] dir_q, dir_d;
   logic [PFM_NPINS-1:0] dout_q, dout_d;
   logic [1:0] clksrc_q, clksrc_d;
   logic [PFM_NPINS-1:0] din_q, din_d;
   logic tx_q, rx_q, xin_q, tb0_q, tb1_q, ta0_q, pwm_q;
   logic tx_d, rx_d, xin_d, tb0_d, tb1_d, ta0_d, pwm_d;
   logic clko;
   logic rst_req;
   logic rst_n;
   logic reset_pin_is_reset;
   logic [PFM_NPINS-1:0] pout, poe;

   function automatic logic [1:0] sel_of(input logic [2*PFM_NPINS-1:0] s, input int unsigned p);
      sel_of = s[2*p +: 2];
   endfunction

   // reset pin is a reset input unless software made it a port bit
   assign reset_pin_is_reset = !en_q[PIN_RST]; // [RULE_09]
   // pad reset only counts while the pin is in reset mode
   assign rst_req = (reset_pin_is_reset && !i_pad_in[PIN_RST]) // [RULE_04]
                    || i_watchdog_reset_source || i_sw_reset; // [RULE_06]

   pfm_rst_sync #(
      .HOLD(HOLD),
      .W(RST_CNT_W)
   ) u_rst (
      .i_clk(i_clk),
      .i_arst_n(i_reset_n),
      .i_req(rst_req),
      .o_rst_n(rst_n)
   );
   assign o_chip_reset_n = rst_n;

   // buffered clock source; glitches on switch are tolerated, a limitation
   always_comb begin
      case (clksrc_q) // [RULE_12]
         CLKO_SRC_SYS: clko = i_sys_clk_src;
         CLKO_SRC_BUS: clko = i_bus_clk_src;
         CLKO_SRC_OSC: clko = i_osc_clk_src;
         CLKO_SRC_OFF: clko = 1'b0;
         default: clko = 1'b0;
      endcase
   end

   // pad drive: exactly one source per pin, the rest isolated
   always_comb begin
      pout = '0;
      poe = '0;
      for (int unsigned p = 0; p < PFM_NPINS; p++) begin
         if (!en_q[p]) begin
            pout[p] = dout_q[p]; // [RULE_03]
            poe[p] = dir_q[p]; // [RULE_03]
         end
      end
      // test clock pin and reset pin in primary mode are pure inputs
      if (!en_q[PIN_TCK]) begin
         pout[PIN_TCK] = 1'b0; // [RULE_08]
         poe[PIN_TCK] = 1'b0;
      end else begin
         pout[PIN_TCK] = dout_q[PIN_TCK];
         poe[PIN_TCK] = dir_q[PIN_TCK];
      end
      if (reset_pin_is_reset) begin
         pout[PIN_RST] = 1'b0;
         poe[PIN_RST] = 1'b0;
      end else begin
         pout[PIN_RST] = dout_q[PIN_RST];
         poe[PIN_RST] = dir_q[PIN_RST];
      end
      // c1 drives the crystal output when enabled
      if (en_q[PIN_C1]) begin
         pout[PIN_C1] = i_crystal_output;
         poe[PIN_C1] = 1'b1;
      end
      if (en_q[PIN_C2]) begin // [RULE_16]
         case (sel_of(sel_q, PIN_C2))
            SEL_ALT0: begin
               pout[PIN_C2] = i_serial_a_transmit; // [RULE_11]
               poe[PIN_C2] = i_serial_a_tx_oe;
            end
            SEL_ALT1: begin
               if (MEMBER == MEMBER_XBAR) begin // [RULE_15]
                  pout[PIN_C2] = i_crossbar_out_eleven;
                  poe[PIN_C2] = 1'b1;
               end else begin
                  pout[PIN_C2] = i_timer_b_chan0;
                  poe[PIN_C2] = i_timer_b_chan0_oe;
               end
            end
            SEL_ALT2: begin
               pout[PIN_C2] = 1'b0;
               poe[PIN_C2] = 1'b0;
            end
            SEL_ALT3: begin
               pout[PIN_C2] = clko; // [RULE_12]
               poe[PIN_C2] = 1'b1;
            end
            default: ;
         endcase
      end
      if (en_q[PIN_F8]) begin // [RULE_16]
         case (sel_of(sel_q, PIN_F8))
            SEL_ALT0: poe[PIN_F8] = 1'b0;
            SEL_ALT1: begin
               if (MEMBER == MEMBER_XBAR) begin
                  pout[PIN_F8] = i_crossbar_out_ten;
                  poe[PIN_F8] = 1'b1;
               end else begin
                  pout[PIN_F8] = i_timer_b_chan1;
                  poe[PIN_F8] = i_timer_b_chan1_oe;
               end
            end
            SEL_ALT2: begin
               pout[PIN_F8] = i_comparator_d_out;
               poe[PIN_F8] = 1'b1;
            end
            SEL_ALT3: begin
               pout[PIN_F8] = i_pwm_sub2_x_pin;
               poe[PIN_F8] = i_pwm_sub2_x_oe;
            end
            default: ;
         endcase
      end
      if (en_q[PIN_C3]) begin // [RULE_16]
         case (sel_of(sel_q, PIN_C3))
            SEL_ALT0: begin
               pout[PIN_C3] = i_timer_a_chan0;
               poe[PIN_C3] = i_timer_a_chan0_oe;
            end
            SEL_ALT1: begin
               pout[PIN_C3] = i_comparator_a_out;
               poe[PIN_C3] = 1'b1;
            end
            SEL_ALT2: poe[PIN_C3] = 1'b0;
            SEL_ALT3: poe[PIN_C3] = 1'b0;
            default: ;
         endcase
      end
   end

   // registered inputs toward peripherals; unselected ones read zero
   always_comb begin
      en_d = i_periph_en; // [RULE_02]
      sel_d = i_periph_sel; // [RULE_02]
      dir_d = i_port_dir;
      dout_d = i_port_dout;
      clksrc_d = i_clock_out_source_field;
      // pins 0 and 1 are port bits when enabled, the others when not
      din_d = i_pad_in & ~en_q;
      din_d[PIN_TCK] = i_pad_in[PIN_TCK] & en_q[PIN_TCK]; // [RULE_03]
      din_d[PIN_RST] = i_pad_in[PIN_RST] & en_q[PIN_RST]; // [RULE_03]
      tx_d = 1'b0;
      rx_d = 1'b0;
      xin_d = 1'b0;
      tb0_d = 1'b0;
      tb1_d = 1'b0;
      ta0_d = 1'b0;
      pwm_d = 1'b0;
      if (en_q[PIN_C2]) begin
         // single-wire: transmit line also carries receive data
         if (sel_of(sel_q, PIN_C2) == SEL_ALT0 && !i_serial_a_tx_oe) tx_d = i_pad_in[PIN_C2]; // [RULE_11]
         if (sel_of(sel_q, PIN_C2) == SEL_ALT2) xin_d = i_pad_in[PIN_C2];
         if (sel_of(sel_q, PIN_C2) == SEL_ALT1 && MEMBER != MEMBER_XBAR) tb0_d = i_pad_in[PIN_C2];
      end
      if (en_q[PIN_F8]) begin
         if (sel_of(sel_q, PIN_F8) == SEL_ALT0) rx_d = i_pad_in[PIN_F8];
         if (sel_of(sel_q, PIN_F8) == SEL_ALT1 && MEMBER != MEMBER_XBAR) tb1_d = i_pad_in[PIN_F8];
         if (sel_of(sel_q, PIN_F8) == SEL_ALT3) pwm_d = i_pad_in[PIN_F8];
      end
      if (en_q[PIN_C3]) begin
         if (sel_of(sel_q, PIN_C3) == SEL_ALT0) ta0_d = i_pad_in[PIN_C3];
         if (sel_of(sel_q, PIN_C3) == SEL_ALT2) rx_d = i_pad_in[PIN_C3];
      end
   end

   // primary functions restored on any reset, including watchdog and software
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_q <= '0; // [RULE_01] [RULE_10] [RULE_13] [RULE_14]
         sel_q <= '0;
         dir_q <= '0;
         dout_q <= '0;
         clksrc_q <= CLKO_SRC_SYS;
         din_q <= '0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
         xin_q <= 1'b0;
         tb0_q <= 1'b0;
         tb1_q <= 1'b0;
         ta0_q <= 1'b0;
         pwm_q <= 1'b0;
      end else if (!rst_n) begin
         en_q <= '0; // [RULE_01]
         sel_q <= '0;
         dir_q <= '0;
         dout_q <= '0;
         clksrc_q <= CLKO_SRC_SYS;
         din_q <= '0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
         xin_q <= 1'b0;
         tb0_q <= 1'b0;
         tb1_q <= 1'b0;
         ta0_q <= 1'b0;
         pwm_q <= 1'b0;
      end else begin
         en_q <= en_d;
         sel_q <= sel_d;
         dir_q <= dir_d;
         dout_q <= dout_d;
         clksrc_q <= clksrc_d;
         din_q <= din_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         xin_q <= xin_d;
         tb0_q <= tb0_d;
         tb1_q <= tb1_d;
         ta0_q <= ta0_d;
         pwm_q <= pwm_d;
      end
   end

   assign o_pad_out = pout;
   assign o_pad_oe = poe;
   assign o_port_din = din_q;
   // test clock is a clock path, passed straight through while selected
   assign o_test_clk = !en_q[PIN_TCK] & i_pad_in[PIN_TCK]; // [RULE_07] [RULE_08]
   // oscillator inputs disconnected unless selected
   assign o_crystal_en = en_q[PIN_C0] & en_q[PIN_C1] & (sel_of(sel_q, PIN_C0) == SEL_ALT0); // [RULE_10]
   assign o_crystal_input = o_crystal_en & i_pad_in[PIN_C0];
   assign o_ext_clock_input_a = en_q[PIN_C0] & (sel_of(sel_q, PIN_C0) == SEL_ALT1) & i_pad_in[PIN_C0];
   assign o_ext_clock_input_b = en_q[PIN_C3] & (sel_of(sel_q, PIN_C3) == SEL_ALT3) & i_pad_in[PIN_C3];
   assign o_serial_a_receive = rx_q | tx_q;
   assign o_crossbar_in_two = xin_q;
   assign o_timer_b_chan0 = tb0_q;
   assign o_timer_b_chan1 = tb1_q;
   assign o_timer_a_chan0 = ta0_q;
   assign o_pwm_sub2_x_pin = pwm_q;
endmodule // pfm_pin_mux
`default_nettype wire

// file: pfm_pin_mux_monitor.sv
// checker: reset, port and routing relations at the mux ports
// bound to pfm_pin_mux; one clock domain
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux_monitor
   import pfm_pkg::*;
#(
   parameter int unsigned HOLD = RST_HOLD_CYC
) (
   // clock, resets, configuration
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_watchdog_reset_source,
   input wire logic i_sw_reset,
   input wire logic [PFM_NPINS-1:0] i_periph_en,
   input wire logic [2*PFM_NPINS-1:0] i_periph_sel,
   input wire logic [PFM_NPINS-1:0] i_port_dir,
   input wire logic [1:0] i_clock_out_source_field,
   // pads and peripherals
   input wire logic [PFM_NPINS-1:0] i_pad_in,
   input wire logic [PFM_NPINS-1:0] o_pad_out,
   input wire logic [PFM_NPINS-1:0] o_pad_oe,
   input wire logic o_test_clk,
   input wire logic o_crystal_en,
   input wire logic i_serial_a_transmit,
   input wire logic i_serial_a_tx_oe,
   input wire logic i_bus_clk_src,
   input wire logic o_chip_reset_n
);
   // release edge is hold+1 edges after the edge that saw the last request
   localparam int unsigned REL = HOLD + 1;
   logic ok_q;
   logic quiet;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // config only follows inputs once internal reset was high an edge ago
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ok_q <= 1'b0;
      end else begin
         ok_q <= o_chip_reset_n;
      end
   end
   assign quiet = !i_sw_reset && !i_watchdog_reset_source;
   chk_reset_idle_pads: assert property (!o_chip_reset_n && !ok_q |-> o_pad_oe == '0)
      else $error("pads driven in reset");
   chk_port_dir: assert property (ok_q |-> ((o_pad_oe ^ $past(i_port_dir)) & ~$past(i_periph_en) & 7'h7c) == '0)
      else $error("port direction wrong");
   chk_tck_route: assert property (ok_q |-> o_test_clk == (i_pad_in[0] && !$past(i_periph_en[0])))
      else $error("test clock routing wrong");
   chk_pin_no_reset: assert property ((ok_q && $past(i_periph_en[1]) && quiet)[*4] |=> o_chip_reset_n)
      else $error("port-mode reset pin reset the chip");
   chk_release_wait: assert property ($rose(o_chip_reset_n) |-> $past(quiet, REL))
      else $error("internal reset released early");
   chk_osc_off: assert property (!(ok_q && $past(i_periph_en[2]) && $past(i_periph_en[3])) |-> !o_crystal_en)
      else $error("crystal enabled unselected");
   chk_tx_route: assert property (ok_q && $past(i_periph_en[4]) && $past(i_periph_sel[9:8]) == SEL_ALT0
      |-> o_pad_out[4] == i_serial_a_transmit && o_pad_oe[4] == i_serial_a_tx_oe)
      else $error("transmit routing wrong");
   chk_clko_source: assert property (ok_q && $past(i_periph_en[4]) && $past(i_periph_sel[9:8]) == SEL_ALT3
      && $past(i_clock_out_source_field) == CLKO_SRC_BUS |-> o_pad_out[4] == i_bus_clk_src)
      else $error("clock out source wrong");
   cover property ($rose(o_chip_reset_n));
   cover property (o_crystal_en);
   cover property (ok_q && $past(i_periph_en[1]) && !i_pad_in[1]);
endmodule // pfm_pin_mux_monitor
bind pfm_pin_mux pfm_pin_mux_monitor #(.HOLD(HOLD)) pfm_pin_mux_monitor_inst (.*);
`default_nettype wire

// file: pfm_periph_model.sv
// peripheral and board model: changing peripheral levels, pad wire
// assumes the bench drives a pad only where the mux leaves it
`timescale 1ns/1ps
`default_nettype none
module pfm_periph_model (
   // clock
   input wire logic i_clk,
   // pad side
   input wire logic [6:0] i_pad_out,
   input wire logic [6:0] i_pad_oe,
   input wire logic [6:0] i_board,
   input wire logic [6:0] i_board_en,
   output logic [6:0] o_pad_in,
   // peripheral levels and clock sources
   output logic [17:0] o_periph
);
   logic [17:0] lf_q = 18'h2a5b1;
   logic tog_q = 1'b0;
   always_ff @(posedge i_clk) begin
      lf_q <= {lf_q[16:0], lf_q[17] ^ lf_q[10]};
      tog_q <= ~tog_q;
   end
   // undriven pads flip every cycle so stale data never matches; pin 0 pulled up
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         o_pad_in[p] = i_pad_oe[p] ? i_pad_out[p] : i_board_en[p] ? i_board[p] : (p == 0) | tog_q;
      end
   end
   assign o_periph = lf_q;
endmodule // pfm_periph_model
`default_nettype wire

// file: pfm_pin_mux_bench.sv
// self-checking bench for the pin mux
// config driven at falling edges; peripherals and board from pfm_periph_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module pfm_pin_mux_bench;
   localparam int unsigned HOLD = 4;
   int bad_count = 0;
   int n_tests = 0;
   logic i_clk, i_reset_n, i_watchdog_reset_source, i_sw_reset, i_crystal_output, o_chip_reset_n;
   logic [6:0] i_periph_en, i_port_dir, i_port_dout, i_pad_in, o_pad_out, o_pad_oe, o_port_din, brd, brd_en;
   logic [13:0] i_periph_sel;
   logic [17:0] pv;
   logic [1:0] i_clock_out_source_field;
   logic o_test_clk, o_crystal_input, o_crystal_en, o_ext_clock_input_a, o_ext_clock_input_b, o_serial_a_receive;
   logic o_crossbar_in_two, o_timer_b_chan0, o_timer_b_chan1, o_timer_a_chan0, o_pwm_sub2_x_pin;
   logic i_serial_a_transmit, i_serial_a_tx_oe, i_crossbar_out_eleven, i_crossbar_out_ten, i_timer_b_chan0;
   logic i_timer_b_chan0_oe, i_timer_b_chan1, i_timer_b_chan1_oe, i_timer_a_chan0, i_timer_a_chan0_oe;
   logic i_comparator_a_out, i_comparator_d_out, i_pwm_sub2_x_pin, i_pwm_sub2_x_oe;
   logic i_sys_clk_src, i_bus_clk_src, i_osc_clk_src;
   assign {i_crystal_output, i_serial_a_transmit, i_serial_a_tx_oe, i_crossbar_out_eleven, i_crossbar_out_ten,
      i_timer_b_chan0, i_timer_b_chan0_oe, i_timer_b_chan1, i_timer_b_chan1_oe, i_timer_a_chan0, i_timer_a_chan0_oe,
      i_comparator_a_out, i_comparator_d_out, i_pwm_sub2_x_pin, i_pwm_sub2_x_oe, i_sys_clk_src, i_bus_clk_src,
      i_osc_clk_src} = pv;
   pfm_pin_mux #(.HOLD(HOLD)) pfm_pin_mux_inst (.*);
   pfm_periph_model pfm_periph_model_inst (.i_clk(i_clk), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
      .i_board(brd), .i_board_en(brd_en), .o_pad_in(i_pad_in), .o_periph(pv));
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic cfg(input logic [6:0] en, input logic [13:0] sel, input logic [6:0] dir, input logic [1:0] f);
      i_periph_en = en;
      i_periph_sel = sel;
      i_port_dir = dir;
      i_clock_out_source_field = f;
      cyc(3);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // bounded wait for internal reset release; k counts falling edges
   task automatic wait_rel(output int k);
      for (k = 0; o_chip_reset_n !== 1'b1; k++) begin
         if (k == 60) begin
            bad_count++;
            tally_and_finish();
         end
         cyc(1);
      end
   endtask
   task automatic t_defaults();
      int k;
      `CHK(o_pad_oe, 7'h00)
      `CHK(o_chip_reset_n, 1'b0)
      i_reset_n = 1'b1;
      wait_rel(k);
      cyc(1);
      `CHK(o_pad_oe, 7'h00)
      `CHK({o_crystal_en, o_ext_clock_input_a}, 2'b00)
      `CHK(o_port_din[6:2], brd[6:2])
      `CHK(o_test_clk, 1'b1)
      brd_en[0] = 1'b1;
      cyc(1);
      `CHK(o_test_clk, 1'b0)
   endtask
   task automatic t_port();
      i_port_dout = 7'h33;
      cfg(7'h03, 14'h0000, 7'h55, 2'h0);
      `CHK(o_pad_oe, 7'h55)
      `CHK(o_pad_out & 7'h55, 7'h11)
      `CHK(o_port_din & 7'h2a, brd & 7'h2a)
      `CHK(o_test_clk, 1'b0)
      brd[1] = 1'b0;
      cyc(12);
      `CHK(o_chip_reset_n, 1'b1)
      brd[1] = 1'b1;
      cfg(7'h00, 14'h0000, 7'h7c, 2'h0);
   endtask
   // watchdog, software, then reset pad; pads must fall back to defaults
   task automatic t_resets();
      int k;
      for (int s = 0; s < 3; s++) begin
         i_watchdog_reset_source = (s == 0);
         i_sw_reset = (s == 1);
         brd[1] = (s != 2);
         cyc(1);
         i_watchdog_reset_source = 1'b0;
         i_sw_reset = 1'b0;
         brd[1] = 1'b1;
         cyc(3);
         `CHK({o_chip_reset_n, o_pad_oe}, 8'h00)
         wait_rel(k);
         `CHK(s == 2 || k + 4 == HOLD + 2, 1'b1)
      end
      cfg(7'h4c, 14'h3000, 7'h00, 2'h0);
      `CHK(o_crystal_en, 1'b1)
      `CHK({o_crystal_input, o_ext_clock_input_b}, {brd[2], brd[6]})
      cfg(7'h4c, 14'h3010, 7'h00, 2'h0);
      `CHK({o_crystal_en, o_ext_clock_input_a}, {1'b0, brd[2]})
   endtask
   // pins c2 and f8 through every select code, c2 clock out through every source
   task automatic t_alt();
      logic e, p;
      brd[5] = 1'b1;
      for (int s = 0; s < 4; s++) begin
         for (int f = 0; f < 4; f++) begin
            brd_en[5:4] = {s == 0, s == 2};
            cfg(7'h30, 14'(s * 5) << 8, 7'h00, 2'(f));
            p = i_pad_in[5];
            for (int j = 0; j < 4; j++) begin
               cyc(1);
               e = s == 0 ? i_serial_a_transmit : s == 1 ? i_crossbar_out_eleven : f == 0 ? i_sys_clk_src :
                  f == 1 ? i_bus_clk_src : f == 2 ? i_osc_clk_src : 1'b0;
               `CHK(s == 2 || o_pad_out[4] === e, 1'b1)
               `CHK(s == 3 || o_pad_oe[4] === (s == 0 ? i_serial_a_tx_oe : s == 1), 1'b1)
               e = s == 1 ? i_crossbar_out_ten : s == 2 ? i_comparator_d_out : i_pwm_sub2_x_pin;
               `CHK(s == 0 || o_pad_out[5] === e, 1'b1)
               `CHK(o_pad_oe[5], s == 3 ? i_pwm_sub2_x_oe : s != 0)
               `CHK(o_pwm_sub2_x_pin, s == 3 && p)
               p = i_pad_in[5];
            end
            `CHK({o_crossbar_in_two, o_serial_a_receive}, {s == 2, s == 0})
         end
      end
   endtask
   // pin c3 through timer, comparator and receive selects; board holds the pad high
   task automatic t_c3();
      logic p;
      for (int s = 0; s < 3; s++) begin
         cfg(7'h40, 14'(s) << 12, 7'h00, 2'h0);
         p = i_pad_in[6];
         cyc(1);
         `CHK(o_timer_a_chan0, s == 0 && p)
         `CHK(o_pad_oe[6], s == 0 ? i_timer_a_chan0_oe : s == 1)
         `CHK(s != 1 || o_pad_out[6] === i_comparator_a_out, 1'b1)
         `CHK({o_serial_a_receive, o_timer_b_chan0, o_timer_b_chan1}, {s == 2, 2'b00})
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      i_reset_n = 1'b0;
      i_watchdog_reset_source = 1'b0;
      i_sw_reset = 1'b0;
      i_port_dout = 7'h00;
      brd = 7'h56;
      brd_en = 7'h7e;
      cfg(7'h00, 14'h0000, 7'h00, 2'h0);
      cyc(7);
      t_defaults();
      t_port();
      t_resets();
      t_alt();
      t_c3();
      tally_and_finish();
   end
endmodule // pfm_pin_mux_bench
`default_nettype wire
